// file: hdl/fcil_top.sv
// flash controller interrupt logic: raw flags, mask, masked status and clear over ahb-lite
// What this block does
// [RULE1] programming raw flag sets on cycle completion
// [RULE2] access raw flag sets on protection violation
// [RULE3] interrupt only when raw and mask set
// [RULE4] programming mask bit one, read-write, reset zero
// [RULE5] access mask bit zero, read-write, reset zero
// [RULE6] masked bit one shows unmasked programming flag
// [RULE7] masked bit zero shows unmasked access flag
// [RULE8] writing one clears programming masked and raw
// [RULE9] writing one clears access masked and raw
// [RULE10] software leaves bits above one unchanged
// [RULE11] control write last starts programming cycle
// [RULE12] zero writes and raw register writes ignored
//
// Decided for this implementation: the AHB-Lite register port.
`include "fcil_defs.svh"

module fcil_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire fcil_pkg::fcil_evt_s evt,
  output logic irq
);

  // ***************************************************************
  // bus front end
  // ***************************************************************
  fcil_pkg::fcil_req_s req;
  logic xfer_done;

  fcil_front u_front (
    .clock(clock),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .req(req),
    .xfer_done(xfer_done)
  );

  // ***************************************************************
  // decode
  // ***************************************************************
  logic wr_hit;
  logic rd_hit;
  logic wr_mask;
  logic wr_clr;
  logic wr_raw;

  // writes of other sizes are dropped: only whole-word writes are supported
  assign wr_hit = xfer_done && req.write && req.word_ok;
  assign rd_hit = xfer_done && !req.write;
  assign wr_mask = wr_hit && (req.addr == `FCIL_OFF_MASK);
  assign wr_clr = wr_hit && (req.addr == `FCIL_OFF_MASKED_CLR);
  // raw status has no write path at all
  assign wr_raw = wr_hit && (req.addr == `FCIL_OFF_RAW_STATUS); // RULE12

  // ***************************************************************
  // raw status flags
  // ***************************************************************
  fcil_pkg::fcil_src_t set_vec;
  fcil_pkg::fcil_src_t clr_vec;
  fcil_pkg::fcil_src_t raw;
  fcil_pkg::fcil_src_t raw_next;

  always_comb begin
    set_vec = '0;
    set_vec[`FCIL_BIT_PROG_DONE] = evt.prog_done; // RULE1
    set_vec[`FCIL_BIT_BAD_ACCESS] = evt.bad_access; // RULE2
  end

  always_comb begin
    clr_vec = '0;
    if (wr_clr) begin
      // only ones clear; zeros leave the flag alone
      clr_vec = hwdata[`FCIL_NUM_SRC-1:0]; // RULE8 RULE9 RULE12
    end
    // a new cycle leaves the completion flag clear until it finishes
    if (evt.prog_start) begin
      clr_vec[`FCIL_BIT_PROG_DONE] = 1'b1; // RULE1 RULE11
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `FCIL_NUM_SRC; gi = gi + 1) begin : g_src
      fcil_flag u_flag (
        .clock(clock),
        .rst(rst),
        .set_evt(set_vec[gi]),
        .clr_evt(clr_vec[gi]),
        .flag(raw[gi]),
        .flag_next(raw_next[gi])
      );
    end
  endgenerate

  // ***************************************************************
  // mask, read data and interrupt
  // ***************************************************************
  fcil_pkg::fcil_top_s s_reg;
  fcil_pkg::fcil_top_s s_next;
  fcil_pkg::fcil_src_t masked;

  assign masked = raw & s_reg.mask; // RULE6 RULE7

  always_comb begin
    s_next = s_reg;
    s_next.hresp = `FCIL_HRESP_OKAY;
    if (wr_mask) begin
      // upper bits are not stored; they read back as zero
      s_next.mask = hwdata[`FCIL_NUM_SRC-1:0]; // RULE4 RULE5
    end
    if (rd_hit) begin
      case (req.addr)
        `FCIL_OFF_RAW_STATUS: begin
          s_next.hrdata = {{(32-`FCIL_NUM_SRC){1'b0}}, raw};
        end
        `FCIL_OFF_MASK: begin
          s_next.hrdata = {{(32-`FCIL_NUM_SRC){1'b0}}, s_reg.mask};
        end
        `FCIL_OFF_MASKED_CLR: begin
          s_next.hrdata = {{(32-`FCIL_NUM_SRC){1'b0}}, masked}; // RULE6 RULE7
        end
        default: begin
          s_next.hrdata = `FCIL_RDATA_RESET;
        end
      endcase
    end
    // built from next values so irq matches the flags it registers beside
    s_next.irq = |(raw_next & s_next.mask); // RULE3
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '{mask: `FCIL_MASK_RESET, hrdata: `FCIL_RDATA_RESET, irq: 1'b0, hresp: `FCIL_HRESP_OKAY};
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata = s_reg.hrdata;
  assign hresp = s_reg.hresp;
  assign irq = s_reg.irq;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clock);
  endclocking

  default disable iff (rst);

  sequence seq_addr_phase;
    hsel && htrans[1] && hready && hreadyout;
  endsequence

  sequence seq_read_masked;
    rd_hit && (req.addr == `FCIL_OFF_MASKED_CLR);
  endsequence

  sequence seq_clear_prog;
    wr_clr && hwdata[`FCIL_BIT_PROG_DONE] && !evt.prog_done;
  endsequence

  sequence seq_clear_bad;
    wr_clr && hwdata[`FCIL_BIT_BAD_ACCESS] && !evt.bad_access;
  endsequence

  property p_bus_answer;
    seq_addr_phase |=> !hreadyout ##1 hreadyout;
  endproperty

  AST_BUS_ANSWER: assert property (p_bus_answer)
    else $error("bus answer not after exactly one wait state");

  AST_PROG_SET: assert property ( // RULE1
    evt.prog_done |=> raw[`FCIL_BIT_PROG_DONE])
    else $error("programming flag not set on completion");

  AST_PROG_START_CLR: assert property ( // RULE1
    evt.prog_start && !evt.prog_done |=> !raw[`FCIL_BIT_PROG_DONE])
    else $error("programming flag not clear after a cycle start");

  AST_BAD_SET: assert property ( // RULE2
    evt.bad_access |=> raw[`FCIL_BIT_BAD_ACCESS] [*1] ##0 $past(evt.bad_access))
    else $error("access flag not set on violation");

  AST_IRQ_CAUSE: assert property ( // RULE3
    ##1 irq == |(raw & s_reg.mask))
    else $error("interrupt does not match raw and mask");

  AST_PROG_DONE_IRQ_ENABLE_WRITE: assert property ( // RULE4
    wr_mask |=> s_reg.mask[`FCIL_BIT_PROG_DONE] == $past(hwdata[`FCIL_BIT_PROG_DONE]))
    else $error("programming mask bit not written");

  AST_PROG_DONE_IRQ_ENABLE_SUPPRESS: assert property ( // RULE4
    !s_reg.mask[`FCIL_BIT_PROG_DONE] && !s_reg.mask[`FCIL_BIT_BAD_ACCESS] && !wr_mask |=> !irq)
    else $error("interrupt raised with both sources masked");

  AST_BAD_ACCESS_IRQ_ENABLE_WRITE: assert property ( // RULE5
    wr_mask |=> s_reg.mask[`FCIL_BIT_BAD_ACCESS] == $past(hwdata[`FCIL_BIT_BAD_ACCESS]))
    else $error("access mask bit not written");

  AST_BAD_ACCESS_IRQ_ENABLE_RECORD: assert property ( // RULE5
    !s_reg.mask[`FCIL_BIT_BAD_ACCESS] && evt.bad_access && !wr_mask |=> raw[`FCIL_BIT_BAD_ACCESS] && !masked[`FCIL_BIT_BAD_ACCESS])
    else $error("masked access event not recorded or not suppressed");

  AST_READ_MASKED_PROG: assert property ( // RULE6
    seq_read_masked |=> hrdata[`FCIL_BIT_PROG_DONE] == $past(masked[`FCIL_BIT_PROG_DONE]))
    else $error("masked programming bit reads wrong");

  AST_READ_MASKED_BAD: assert property ( // RULE7
    seq_read_masked |=> hrdata[`FCIL_BIT_BAD_ACCESS] == $past(masked[`FCIL_BIT_BAD_ACCESS]) && hrdata[31:2] == 30'h0)
    else $error("masked access bit reads wrong");

  AST_W1C_PROG: assert property ( // RULE8
    seq_clear_prog |=> !raw[`FCIL_BIT_PROG_DONE] && !masked[`FCIL_BIT_PROG_DONE])
    else $error("programming flag survived a clear");

  AST_W1C_BAD: assert property ( // RULE9
    seq_clear_bad |=> !raw[`FCIL_BIT_BAD_ACCESS] && !masked[`FCIL_BIT_BAD_ACCESS])
    else $error("access flag survived a clear");

  AST_ZERO_WRITE_KEEPS: assert property ( // RULE12
    wr_clr && !hwdata[`FCIL_BIT_PROG_DONE] && !evt.prog_start && raw[`FCIL_BIT_PROG_DONE] |=> raw[`FCIL_BIT_PROG_DONE])
    else $error("zero write cleared the programming flag");

  AST_RAW_WRITE_IGNORED: assert property ( // RULE12
    wr_raw && !evt.prog_start && !evt.prog_done && !evt.bad_access |=> raw == $past(raw))
    else $error("raw status changed by a write");

  // ***************************************************************
  // checks: read path, holding and interrupt raise
  // ***************************************************************
  sequence seq_read_raw;
    rd_hit && (req.addr == `FCIL_OFF_RAW_STATUS);
  endsequence

  sequence seq_read_mask;
    rd_hit && (req.addr == `FCIL_OFF_MASK);
  endsequence

  // unmapped offsets alias nothing and read as zero
  sequence seq_read_other;
    rd_hit && (req.addr != `FCIL_OFF_RAW_STATUS) && (req.addr != `FCIL_OFF_MASK)
      && (req.addr != `FCIL_OFF_MASKED_CLR);
  endsequence

  // no event and no clear: nothing may move the flags
  sequence seq_quiet_flags;
    !wr_clr && !evt.prog_start && !evt.prog_done && !evt.bad_access;
  endsequence

  AST_READ_RAW: assert property ( // RULE1 RULE2
    seq_read_raw |=> hrdata == {30'h0, $past(raw)})
    else $error("raw status reads wrong");

  AST_READ_MASK: assert property ( // RULE4 RULE5
    seq_read_mask |=> hrdata == {30'h0, $past(s_reg.mask)})
    else $error("mask reads wrong");

  AST_READ_OTHER: assert property (
    seq_read_other |=> hrdata == `FCIL_RDATA_RESET)
    else $error("unmapped offset read not zero");

  // read data stands until the next read so a slow master can still take it
  AST_HRDATA_HOLDS: assert property (
    !rd_hit |=> $stable(hrdata))
    else $error("read data moved outside a read");

  AST_MASK_HOLDS: assert property ( // RULE4 RULE5
    !wr_mask |=> s_reg.mask == $past(s_reg.mask))
    else $error("mask changed without a mask write");

  AST_RAW_HOLDS: assert property ( // RULE12
    seq_quiet_flags |=> raw == $past(raw))
    else $error("raw status changed with no event or clear");

  AST_ZERO_WRITE_KEEPS_BAD: assert property ( // RULE12
    wr_clr && !hwdata[`FCIL_BIT_BAD_ACCESS] && raw[`FCIL_BIT_BAD_ACCESS] |=> raw[`FCIL_BIT_BAD_ACCESS])
    else $error("zero write cleared the access flag");

  // sub-word writes are dropped, not merged: keeps the write path one word wide
  AST_NON_WORD_IGNORED: assert property (
    xfer_done && req.write && !req.word_ok && !evt.prog_start && !evt.prog_done && !evt.bad_access
      |=> raw == $past(raw) && s_reg.mask == $past(s_reg.mask))
    else $error("sub-word write changed a register");

  AST_IRQ_PROG_EVENT: assert property ( // RULE3
    evt.prog_done && s_reg.mask[`FCIL_BIT_PROG_DONE] && !wr_mask |=> irq)
    else $error("unmasked completion raised no interrupt");

  AST_IRQ_BAD_EVENT: assert property ( // RULE3
    evt.bad_access && s_reg.mask[`FCIL_BIT_BAD_ACCESS] && !wr_mask |=> irq)
    else $error("unmasked violation raised no interrupt");

endmodule : fcil_top

// file: inc/fcil_defs.svh
// register offsets, field positions, reset values and bus codes of the flash interrupt logic
`ifndef FCIL_DEFS_SVH
`define FCIL_DEFS_SVH

// ***************************************************************
// register map
// ***************************************************************
`define FCIL_ADDR_W 12
`define FCIL_OFF_RAW_STATUS 12'h00c
`define FCIL_OFF_MASK 12'h010
`define FCIL_OFF_MASKED_CLR 12'h014

// ***************************************************************
// fields
// ***************************************************************
`define FCIL_NUM_SRC 2
`define FCIL_BIT_BAD_ACCESS 0
`define FCIL_BIT_PROG_DONE 1
`define FCIL_RAW_RESET 2'h0
`define FCIL_MASK_RESET 2'h0
`define FCIL_RDATA_RESET 32'h0000_0000

// ***************************************************************
// bus codes
// ***************************************************************
`define FCIL_HRESP_OKAY 1'b0
`define FCIL_HSIZE_WORD 3'h2

`endif

// file: inc/fcil_pkg.sv
// types shared by the flash interrupt logic modules
`include "fcil_defs.svh"

package fcil_pkg;

  // ***************************************************************
  // vectors and enumerations
  // ***************************************************************
  typedef logic [`FCIL_NUM_SRC-1:0] fcil_src_t;

  typedef enum logic [0:0] {
    FCIL_BUS_IDLE = 1'b0,
    FCIL_BUS_DATA = 1'b1
  } fcil_bus_e;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic prog_start;
    logic prog_done;
    logic bad_access;
  } fcil_evt_s;

  typedef struct packed {
    logic write;
    logic word_ok;
    logic [`FCIL_ADDR_W-1:0] addr;
  } fcil_req_s;

  // ***************************************************************
  // module state
  // ***************************************************************
  typedef struct packed {
    fcil_bus_e state;
    fcil_req_s req;
    logic hreadyout;
  } fcil_front_s;

  typedef struct packed {
    logic flag;
  } fcil_flag_s;

  typedef struct packed {
    fcil_src_t mask;
    logic [31:0] hrdata;
    logic irq;
    logic hresp;
  } fcil_top_s;

endpackage : fcil_pkg

// file: hdl/fcil_flag.sv
// one sticky raw status flag with set priority over clear
`include "fcil_defs.svh"

module fcil_flag (
  input wire logic clock,
  input wire logic rst,
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag,
  output logic flag_next
);

  fcil_pkg::fcil_flag_s s_reg;
  fcil_pkg::fcil_flag_s s_next;

  // ***************************************************************
  // next state
  // ***************************************************************
  // an event landing in the clearing cycle must not be lost
  always_comb begin
    s_next = s_reg;
    if (set_evt) begin
      s_next.flag = 1'b1;
    end else if (clr_evt) begin
      s_next.flag = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign flag = s_reg.flag;
  assign flag_next = s_next.flag;

  // ***************************************************************
  // checks
  // ***************************************************************
  AST_SET_WINS: assert property (@(posedge clock) disable iff (rst)
    set_evt && clr_evt |=> flag)
    else $error("flag lost an event that met its clear");

endmodule : fcil_flag

// file: hdl/fcil_front.sv
// ahb-lite address phase capture with one wait state per transfer
`include "fcil_defs.svh"

module fcil_front (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output fcil_pkg::fcil_req_s req,
  output logic xfer_done
);

  fcil_pkg::fcil_front_s s_reg;
  fcil_pkg::fcil_front_s s_next;

  // ***************************************************************
  // next state
  // ***************************************************************
  // the wait state lets a write settle before any following read samples it
  always_comb begin
    s_next = s_reg;
    case (s_reg.state)
      fcil_pkg::FCIL_BUS_IDLE: begin
        if (hsel && htrans[1] && hready) begin
          s_next.state = fcil_pkg::FCIL_BUS_DATA;
          s_next.req.write = hwrite;
          s_next.req.word_ok = (hsize == `FCIL_HSIZE_WORD);
          s_next.req.addr = haddr[`FCIL_ADDR_W-1:0];
          s_next.hreadyout = 1'b0;
        end
      end
      fcil_pkg::FCIL_BUS_DATA: begin
        s_next.state = fcil_pkg::FCIL_BUS_IDLE;
        s_next.hreadyout = 1'b1;
      end
      default: begin
        s_next.state = fcil_pkg::FCIL_BUS_IDLE;
        s_next.hreadyout = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '{state: fcil_pkg::FCIL_BUS_IDLE, req: '0, hreadyout: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.hreadyout;
  assign req = s_reg.req;
  assign xfer_done = (s_reg.state == fcil_pkg::FCIL_BUS_DATA);

endmodule : fcil_front

// file: bench/fcil_flash_model.sv
// behavioural flash engine that raises the programming and access events
module fcil_flash_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic start_req,
  input wire logic bad_req,
  input wire logic [7:0] busy_cycles,
  output fcil_pkg::fcil_evt_s evt,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // engine
  // ****************
  logic [7:0] cnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evt <= '0;
      busy <= 1'b0;
      cnt <= 8'h00;
    end else begin
      evt.bad_access <= bad_req;
      // a control write starts the cycle; completion comes only later
      evt.prog_start <= start_req;
      evt.prog_done <= !start_req && busy && (cnt == 8'h01);
      if (start_req) begin
        cnt <= busy_cycles;
        busy <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          busy <= 1'b0;
        end
      end
    end
  end
endmodule : fcil_flash_model

// file: bench/testbench.sv
// self-checking bench for the flash interrupt logic
`include "fcil_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // signals
  // ****************
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic irq;
  logic start_req = 1'b0;
  logic bad_req = 1'b0;
  logic busy;
  logic [7:0] busy_cycles = 8'h14;
  logic [2:0] xfer_size = `FCIL_HSIZE_WORD;
  fcil_pkg::fcil_evt_s evt;
  logic [31:0] exp_q[$];
  logic rd_pend = 1'b0;
  int err_total = 0;
  int check_count = 0;
  always #25 clock = ~clock;

  fcil_top fcil_top_i (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .evt(evt), .irq(irq));
  fcil_flash_model fcil_flash_model_i (.clock(clock), .rst(rst), .start_req(start_req),
    .bad_req(bad_req), .busy_cycles(busy_cycles), .evt(evt), .busy(busy));

  // ****************
  // reporting
  // ****************
  task automatic fail(input string msg);
    $display("Error %0t: %s", $time, msg);
    err_total++;
  endtask : fail

  task automatic close_out();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk_rd(input logic [31:0] exp);
    check_count++;
    if (hrdata !== exp || hresp !== `FCIL_HRESP_OKAY) fail("read data mismatch");
  endtask : chk_rd

  // one edge of slack so a registered irq has landed
  task automatic chk_irq(input logic exp);
    @(posedge clock);
    check_count++;
    if (irq !== exp) fail("irq level mismatch");
  endtask : chk_irq

  // ****************
  // bus master
  // ****************
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      if (n == 20) begin
        fail("bus wait ran out");
        close_out();
      end
      n++;
      @(posedge clock);
    end
  endtask : wait_ready

  task automatic ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    hsize <= xfer_size;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask : ahb_xfer

  task automatic ahb_write(input logic [11:0] a, input logic [31:0] d);
    ahb_xfer(1'b1, a, d);
  endtask : ahb_write

  task automatic ahb_read(input logic [11:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    ahb_xfer(1'b0, a, 32'h0000_0000);
  endtask : ahb_read

  // read data is judged where the master takes it
  always @(posedge clock) begin
    if (rd_pend && hreadyout === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected read data");
      else chk_rd(exp_q.pop_front());
    end
    if (hreadyout === 1'b1) rd_pend <= hsel && htrans[1] && !hwrite;
  end

  // ****************
  // flash events
  // ****************
  task automatic flash_op();
    int n;
    n = 0;
    start_req <= 1'b1;
    @(posedge clock);
    start_req <= 1'b0;
    ahb_read(`FCIL_OFF_RAW_STATUS, 32'h0);
    while (busy === 1'b1 && n < 60) begin
      n++;
      @(posedge clock);
    end
    if (n == 60) begin
      fail("flash cycle never ended");
      close_out();
    end
    repeat (2) @(posedge clock);
  endtask : flash_op

  task automatic bad_op();
    bad_req <= 1'b1;
    @(posedge clock);
    bad_req <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : bad_op

  // ****************
  // scenarios
  // ****************
  initial begin
    logic [1:0] r;
    void'($urandom(22));
    r = 2'($urandom);
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk_irq(1'b0);
    ahb_read(`FCIL_OFF_RAW_STATUS, 32'h0);
    ahb_read(`FCIL_OFF_MASK, 32'h0);
    ahb_read(`FCIL_OFF_MASKED_CLR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      ahb_write(`FCIL_OFF_MASK, {30'h0, r + 2'(i)});
      ahb_read(`FCIL_OFF_MASK, {30'h0, r + 2'(i)});
      ahb_read(`FCIL_OFF_MASKED_CLR, 32'h0);
    end
    ahb_write(`FCIL_OFF_MASK, 32'h0);
    busy_cycles <= 8'h10 + 8'($urandom % 16);
    flash_op();
    ahb_read(`FCIL_OFF_RAW_STATUS, 32'h2);
    ahb_read(`FCIL_OFF_MASKED_CLR, 32'h0);
    chk_irq(1'b0);
    ahb_write(`FCIL_OFF_MASK, 32'h2);
    chk_irq(1'b1);
    ahb_read(`FCIL_OFF_MASKED_CLR, 32'h2);
    ahb_write(`FCIL_OFF_MASKED_CLR, 32'h0);
    ahb_write(`FCIL_OFF_RAW_STATUS, 32'h3);
    ahb_read(`FCIL_OFF_RAW_STATUS, 32'h2);
    bad_op();
    ahb_read(`FCIL_OFF_RAW_STATUS, 32'h3);
    ahb_read(`FCIL_OFF_MASKED_CLR, 32'h2);
    ahb_write(`FCIL_OFF_MASK, 32'h1);
    chk_irq(1'b1);
    ahb_read(`FCIL_OFF_MASKED_CLR, 32'h1);
    ahb_write(`FCIL_OFF_MASKED_CLR, 32'h2);
    ahb_read(`FCIL_OFF_RAW_STATUS, 32'h1);
    ahb_write(`FCIL_OFF_MASK, 32'h3);
    // a byte write must not touch the mask
    xfer_size = 3'h0;
    ahb_write(`FCIL_OFF_MASK, 32'h0);
    xfer_size = `FCIL_HSIZE_WORD;
    ahb_read(`FCIL_OFF_MASK, 32'h3);
    ahb_write(`FCIL_OFF_MASKED_CLR, 32'h1);
    ahb_read(`FCIL_OFF_RAW_STATUS, 32'h0);
    chk_irq(1'b0);
    // a violation landing on its own clear must survive
    bad_req <= 1'b1;
    fork
      ahb_write(`FCIL_OFF_MASKED_CLR, 32'h1);
      begin
        @(posedge clock);
        bad_req <= 1'b0;
      end
    join
    ahb_read(`FCIL_OFF_RAW_STATUS, 32'h1);
    chk_irq(1'b1);
    ahb_write(`FCIL_OFF_MASKED_CLR, 32'h1);
    chk_irq(1'b0);
    flash_op();
    chk_irq(1'b1);
    // a new cycle over a set completion flag must clear it first
    flash_op();
    chk_irq(1'b1);
    ahb_write(`FCIL_OFF_MASKED_CLR, 32'h2);
    ahb_read(`FCIL_OFF_MASKED_CLR, 32'h0);
    chk_irq(1'b0);
    ahb_read(12'h020, 32'h0);
    @(posedge clock);
    if (exp_q.size() != 0) fail("reads left unanswered");
    close_out();
  end
endmodule : testbench
